// ===== rtl/trig_regs.svh
`ifndef TRIG_REGS_SVH
`define TRIG_REGS_SVH

// ==========================================================
// csr addresses
`define CSR_SELECT_ADDR      12'h7a0
`define CSR_MATCH_CTRL_ADDR  12'h7a1
`define CSR_COMPARE_ADDR     12'h7a2

// ==========================================================
// match control field positions
`define TYPE_MSB             31
`define TYPE_LSB             28
`define DMODE_BIT            27
`define MASKMAX_MSB          26
`define MASKMAX_LSB          21
`define ACTION_MSB           15
`define ACTION_LSB           12
`define CHAIN_BIT            11
`define MSIZE_MSB            10
`define MSIZE_LSB            7
`define MEN_BIT              6
`define INDEX_MSB            1

// ==========================================================
// constant and reset values
`define TYPE_VALUE           4'h2
`define MASKMAX_VALUE        6'h1f
`define RST_INDEX            2'h0
`define RST_DMODE            1'b0
`define RST_CHAIN            1'b0
`define RST_MEN              1'b0
`define RST_COMPARE          32'h0000_0000
`define RST_RDATA            32'h0000_0000

`endif

// ===== rtl/trig_pkg.sv
package trig_pkg;

  // ==========================================================
  // types
  typedef logic [11:0] csr_addr_t;
  typedef logic [1:0]  trig_idx_t;
  typedef logic [31:0] word_t;

  typedef enum logic [3:0] {
    MSIZE_EXACT = 4'h0,
    MSIZE_NAPOT = 4'h1
  } match_size_t;

  typedef enum logic [3:0] {
    ACT_BREAK = 4'h0,
    ACT_DEBUG = 4'h1
  } action_t;

endpackage : trig_pkg

// ===== rtl/trig_match_unit.sv
`timescale 1ns/1ps

module trig_match_unit
  import trig_pkg::*;
(
  // compared operands
  input  wire logic        [31:0] value_in,
  input  wire logic        [31:0] compare_in,
  input  wire match_size_t        msize_in,
  // result
  output wire logic               hit_out
);

  wire logic [31:0] cmp_inc;
  wire logic [31:0] napot_mask;
  wire logic        exact_hit;
  wire logic        napot_hit;

  // ==========================================================
  // comparison
  // mask keeps bits above the lowest zero of the compare word
  assign cmp_inc    = compare_in + 32'h0000_0001;
  assign napot_mask = ~(compare_in ^ cmp_inc);
  assign exact_hit  = (value_in == compare_in);
  assign napot_hit  = ((value_in & napot_mask) == (compare_in & napot_mask));

  assign hit_out = (msize_in == MSIZE_EXACT) ? exact_hit :
                   (msize_in == MSIZE_NAPOT) ? napot_hit : 1'b0;

endmodule : trig_match_unit

// ===== rtl/trigger_chain_match_control.sv
`timescale 1ns/1ps
`include "trig_regs.svh"

// Overview of operation
// - chain bit 11 clear: independent match; set: needs next trigger matching too.
// - chain only on triggers 0 and 2; bit stays zero on 1 and 3.
// - chained pair uses only the second trigger's action.
// - chained pair fires only when both triggers match in the same cycle.
// - write with dmode zero clears chain if next trigger has dmode one.
// - discard write setting dmode one when previous trigger chained, dmode zero.
// - match size zero means exact equality with the compare value register.
// - match size one compares top M bits, M from lowest zero bit.
// - machine-mode enable bit 6 lets trigger fire in machine mode.
// - supervisor bit 4 and user bit 3 read zero, not writable.
// - bit 5 reserved, always reads zero.
// - dmode bit 27 set blocks machine-mode writes to trigger data registers.
// - two-bit index selects which trigger the data registers address.

module trigger_chain_match_control
  import trig_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // csr access
  input  wire logic        csr_wr_en_in,
  input  wire logic        csr_rd_en_in,
  input  wire csr_addr_t   csr_addr_in,
  input  wire logic [31:0] csr_wdata_in,
  output wire logic [31:0] csr_rdata_out,
  // hart state
  input  wire logic        debug_mode_in,
  input  wire logic        machine_mode_in,
  // pipeline compare stream
  input  wire logic        compare_valid_in,
  input  wire logic [31:0] compare_value_in,
  // trigger results
  output wire logic [3:0]  match_out,
  output wire logic [3:0]  fire_out,
  output wire logic [15:0] fire_action_out
);

  localparam int NUM_TRIG = 4;

  // ==========================================================
  // decode helper
  function automatic logic csr_hit(input csr_addr_t addr, input csr_addr_t target);
    csr_hit = (addr == target);
  endfunction : csr_hit

  // ==========================================================
  // storage
  trig_idx_t   idx_ff;
  logic        dmode_ff   [NUM_TRIG];
  logic        chain_ff   [NUM_TRIG];
  match_size_t msize_ff   [NUM_TRIG];
  logic        men_ff     [NUM_TRIG];
  action_t     action_ff  [NUM_TRIG];
  word_t       cmp_ff     [NUM_TRIG];
  word_t       rdata_ff;
  logic [3:0]  match_ff;
  logic [3:0]  fire_ff;
  logic [15:0] fire_action_ff;

  // ==========================================================
  // access decode
  wire logic        wr_select;
  wire logic        wr_ctrl;
  wire logic        wr_cmp;
  wire logic        new_dmode;
  wire logic [3:0]  wdata_msize;
  wire logic [3:0]  wdata_action;
  wire logic        msize_legal;
  wire logic        action_legal;
  wire logic        data_wr_ok [NUM_TRIG];
  wire logic        ctrl_wr    [NUM_TRIG];
  wire logic        cmp_wr     [NUM_TRIG];
  wire logic        discard    [NUM_TRIG];
  wire logic        nxt_chain  [NUM_TRIG];
  wire logic [3:0]  unit_hit;
  wire logic [3:0]  raw_match;
  wire logic [3:0]  nxt_fire;
  wire logic [15:0] nxt_fire_action;

  assign wr_select = csr_wr_en_in && csr_hit(csr_addr_in, `CSR_SELECT_ADDR);
  assign wr_ctrl   = csr_wr_en_in && csr_hit(csr_addr_in, `CSR_MATCH_CTRL_ADDR);
  assign wr_cmp    = csr_wr_en_in && csr_hit(csr_addr_in, `CSR_COMPARE_ADDR);

  // dmode itself changes only from debug mode
  assign new_dmode    = debug_mode_in ? csr_wdata_in[`DMODE_BIT] : dmode_ff[idx_ff];
  assign wdata_msize  = csr_wdata_in[`MSIZE_MSB:`MSIZE_LSB];
  assign wdata_action = csr_wdata_in[`ACTION_MSB:`ACTION_LSB];
  assign msize_legal  = (wdata_msize == MSIZE_EXACT) || (wdata_msize == MSIZE_NAPOT);
  assign action_legal = (wdata_action == ACT_BREAK) ||
                        ((wdata_action == ACT_DEBUG) && new_dmode);

  // ==========================================================
  // trigger select
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_ff <= `RST_INDEX;
    end else if (wr_select) begin
      idx_ff <= csr_wdata_in[`INDEX_MSB:0];
    end
  end

  // ==========================================================
  // per-trigger registers
  genvar i;
  generate
    for (i = 0; i < NUM_TRIG; i++) begin : g_trig
      assign data_wr_ok[i] = (idx_ff == trig_idx_t'(i)) &&
                             (debug_mode_in || !dmode_ff[i]);

      if (i > 0) begin : g_prev
        assign discard[i] = debug_mode_in && csr_wdata_in[`DMODE_BIT] &&
                            !dmode_ff[i-1] && chain_ff[i-1];
      end else begin : g_noprev
        assign discard[i] = 1'b0;
      end

      assign ctrl_wr[i] = wr_ctrl && data_wr_ok[i] && !discard[i];
      assign cmp_wr[i]  = wr_cmp && data_wr_ok[i];

      if ((i % 2) == 0) begin : g_chainable
        assign nxt_chain[i] = csr_wdata_in[`CHAIN_BIT] &&
                              !(!new_dmode && dmode_ff[i+1]);
      end else begin : g_unchained
        assign nxt_chain[i] = 1'b0;
      end

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          dmode_ff[i] <= `RST_DMODE;
          chain_ff[i] <= `RST_CHAIN;
          men_ff[i]   <= `RST_MEN;
        end else if (ctrl_wr[i]) begin
          dmode_ff[i] <= new_dmode;
          chain_ff[i] <= nxt_chain[i];
          men_ff[i]   <= csr_wdata_in[`MEN_BIT];
        end
      end

      // unsupported encodings leave the field unchanged
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          msize_ff[i]  <= MSIZE_EXACT;
          action_ff[i] <= ACT_BREAK;
        end else if (ctrl_wr[i]) begin
          if (msize_legal) begin
            msize_ff[i] <= match_size_t'(wdata_msize);
          end
          if (action_legal) begin
            action_ff[i] <= action_t'(wdata_action);
          end
        end
      end

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cmp_ff[i] <= `RST_COMPARE;
        end else if (cmp_wr[i]) begin
          cmp_ff[i] <= csr_wdata_in;
        end
      end

      trig_match_unit u_match (
        .value_in   (compare_value_in),
        .compare_in (cmp_ff[i]),
        .msize_in   (msize_ff[i]),
        .hit_out    (unit_hit[i])
      );

      assign raw_match[i] = compare_valid_in && machine_mode_in &&
                            men_ff[i] && unit_hit[i];
    end
  endgenerate

  // ==========================================================
  // chain resolution
  generate
    for (i = 0; i < NUM_TRIG; i += 2) begin : g_pair
      assign nxt_fire[i]   = raw_match[i] && !chain_ff[i];
      assign nxt_fire[i+1] = chain_ff[i] ? (raw_match[i] && raw_match[i+1])
                                         : raw_match[i+1];
      // the pair's second slot carries its own action whenever it fires, chained or not
      assign nxt_fire_action[4*i+3:4*i]     = nxt_fire[i] ? action_ff[i] : ACT_BREAK;
      assign nxt_fire_action[4*i+7:4*i+4]   = nxt_fire[i+1] ? action_ff[i+1]
                                                            : ACT_BREAK;
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_ff       <= 4'h0;
      fire_ff        <= 4'h0;
      fire_action_ff <= 16'h0000;
    end else begin
      match_ff       <= raw_match;
      fire_ff        <= nxt_fire;
      fire_action_ff <= nxt_fire_action;
    end
  end

  // ==========================================================
  // read path
  wire word_t rd_select_word;
  wire word_t rd_ctrl_word;
  wire word_t rd_word;

  assign rd_select_word = {30'h0, idx_ff};

  // hit, select, timing, sizelo and the event enables belong elsewhere
  assign rd_ctrl_word = {`TYPE_VALUE,
                         dmode_ff[idx_ff],
                         `MASKMAX_VALUE,
                         3'h0,
                         2'h0,
                         action_ff[idx_ff],
                         chain_ff[idx_ff],
                         msize_ff[idx_ff],
                         men_ff[idx_ff],
                         3'h0,
                         3'h0};

  assign rd_word = csr_hit(csr_addr_in, `CSR_SELECT_ADDR)     ? rd_select_word :
                   csr_hit(csr_addr_in, `CSR_MATCH_CTRL_ADDR) ? rd_ctrl_word   :
                   csr_hit(csr_addr_in, `CSR_COMPARE_ADDR)    ? cmp_ff[idx_ff] :
                   32'h0000_0000;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= `RST_RDATA;
    end else if (csr_rd_en_in) begin
      rdata_ff <= rd_word;
    end
  end

  // ==========================================================
  // outputs
  assign csr_rdata_out   = rdata_ff;
  assign match_out       = match_ff;
  assign fire_out        = fire_ff;
  assign fire_action_out = fire_action_ff;

endmodule : trigger_chain_match_control

// ===== testbench/tcm_sva.sv
`timescale 1ns/1ps
`include "trig_regs.svh"

// ======
// port checker
module tcm_sva
  import trig_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        csr_wr_en_in,
  input wire logic        csr_rd_en_in,
  input wire csr_addr_t   csr_addr_in,
  input wire logic [31:0] csr_wdata_in,
  input wire logic [31:0] csr_rdata_out,
  input wire logic        machine_mode_in,
  input wire logic        compare_valid_in,
  input wire logic [3:0]  match_out,
  input wire logic [3:0]  fire_out,
  input wire logic [15:0] fire_action_out
);
  trig_idx_t idx_ff;
  wire rd_sel = csr_rd_en_in && csr_addr_in == `CSR_SELECT_ADDR;
  wire rd_ctl = csr_rd_en_in && csr_addr_in == `CSR_MATCH_CTRL_ADDR;
  wire rd_cmp = csr_rd_en_in && csr_addr_in == `CSR_COMPARE_ADDR;
  wire rd_bad = csr_rd_en_in && !(rd_sel || rd_ctl || rd_cmp);
  wire [3:0] act_nz = {|fire_action_out[15:12], |fire_action_out[11:8],
                       |fire_action_out[7:4], |fire_action_out[3:0]};

  // shadow of the selected trigger
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_ff <= `RST_INDEX;
    end else if (csr_wr_en_in && csr_addr_in == `CSR_SELECT_ADDR) begin
      idx_ff <= csr_wdata_in[`INDEX_MSB:0];
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_ctl; rd_ctl; endsequence

  property p_chain_odd; s_rd_ctl ##0 idx_ff[0] |=> !csr_rdata_out[11]; endproperty
  property p_msize; s_rd_ctl |=> csr_rdata_out[10:7] <= 4'h1; endproperty
  property p_fixed; s_rd_ctl |=> csr_rdata_out[5:0] == 6'h00 &&
    csr_rdata_out[31:28] == 4'h2 && csr_rdata_out[26:16] == 11'h3e0; endproperty
  property p_sel; rd_sel |=> csr_rdata_out[31:2] == 30'h0; endproperty
  property p_unmap; rd_bad |=> csr_rdata_out == 32'h0; endproperty
  property p_stand; !csr_rd_en_in |=> $stable(csr_rdata_out); endproperty
  property p_cause; |match_out |-> $past(compare_valid_in) && $past(machine_mode_in); endproperty
  property p_fire; (fire_out & ~match_out) == 4'h0; endproperty
  property p_act; (act_nz & ~fire_out) == 4'h0 && (fire_action_out & 16'heeee) == 16'h0;
  endproperty
  // both members matching always fires the pair's second slot
  sequence s_both_lo; match_out[1:0] == 2'b11; endsequence
  sequence s_both_hi; match_out[3:2] == 2'b11; endsequence
  property p_pair_lo; s_both_lo |-> fire_out[1]; endproperty
  property p_pair_hi; s_both_hi |-> fire_out[3]; endproperty

  a_chain_odd: assert property (p_chain_odd) else $error("chain set on odd trigger");
  a_msize: assert property (p_msize) else $error("bad match size");
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  a_sel: assert property (p_sel) else $error("select upper bits set");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_stand: assert property (p_stand) else $error("read data moved");
  a_cause: assert property (p_cause) else $error("match without cause");
  a_fire: assert property (p_fire) else $error("fire without match");
  a_act: assert property (p_act) else $error("stray action");
  a_pair_lo: assert property (p_pair_lo) else $error("pair 0/1 did not fire");
  a_pair_hi: assert property (p_pair_hi) else $error("pair 2/3 did not fire");
endmodule : tcm_sva

bind trigger_chain_match_control tcm_sva u_sva (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .csr_wr_en_in(csr_wr_en_in),
  .csr_rd_en_in(csr_rd_en_in), .csr_addr_in(csr_addr_in), .csr_wdata_in(csr_wdata_in),
  .csr_rdata_out(csr_rdata_out), .machine_mode_in(machine_mode_in),
  .compare_valid_in(compare_valid_in), .match_out(match_out), .fire_out(fire_out),
  .fire_action_out(fire_action_out)
);

// ===== testbench/pipe_model.sv
`timescale 1ns/1ps

// ======
// pipeline compare stream source
module pipe_model (
  input  wire logic  mclk_in,
  output logic       cv_out,
  output logic [31:0] cval_out
);
  initial begin
    cv_out = 1'b0;
    cval_out = 32'h0;
  end

  task automatic send(input logic [31:0] v);
    @(posedge mclk_in);
    #1;
    cv_out = 1'b1;
    cval_out = v;
    @(posedge mclk_in);
    #1;
    cv_out = 1'b0;
    // no stale value once invalid
    cval_out = ~v;
  endtask : send
endmodule : pipe_model

// ===== testbench/trigger_chain_match_control_bench.sv
`timescale 1ns/1ps

module trigger_chain_match_control_bench
  import trig_pkg::*;
;
  localparam csr_addr_t a_sel = 12'h7a0, a_ctl = 12'h7a1, a_cmp = 12'h7a2;
  logic clk, rst_n, wr, rd, dbg, mm;
  csr_addr_t   addr;
  logic [31:0] wd;
  wire [31:0]  rdat, cval;
  wire         cv;
  wire [3:0]   mt, ft;
  wire [15:0]  fa;
  int          error_cnt, samples_checked;

  trigger_chain_match_control uut (.mclk_in(clk), .rst_n_in(rst_n), .csr_wr_en_in(wr),
    .csr_rd_en_in(rd), .csr_addr_in(addr), .csr_wdata_in(wd), .csr_rdata_out(rdat),
    .debug_mode_in(dbg), .machine_mode_in(mm), .compare_valid_in(cv),
    .compare_value_in(cval), .match_out(mt), .fire_out(ft), .fire_action_out(fa));
  pipe_model pm (.mclk_in(clk), .cv_out(cv), .cval_out(cval));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_csr(input csr_addr_t a, input logic [31:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : wr_csr

  task automatic rd_csr(input csr_addr_t a, input logic [31:0] exp);
    @(posedge clk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    cmp(rdat, exp);
  endtask : rd_csr

  task automatic stream(input logic [31:0] v, input logic [3:0] m, input logic [3:0] f,
                        input logic [15:0] a);
    pm.send(v);
    cmp({28'h0, mt}, {28'h0, m});
    cmp({28'h0, ft}, {28'h0, f});
    cmp({16'h0, fa}, {16'h0, a});
  endtask : stream

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, dbg, addr, wd} = '0;
    mm = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_csr(a_sel, 32'h0);
    rd_csr(a_ctl, 32'h23e0_0000);
    rd_csr(a_cmp, 32'h0);
    rd_csr(12'h7a3, 32'h0);
    $display("test reset done");
    wr_csr(a_ctl, 32'hffff_ffff);
    rd_csr(a_ctl, 32'h23e0_0840);
    for (int i = 1; i < 4; i += 2) begin
      wr_csr(a_sel, i);
      wr_csr(a_ctl, 32'h0000_0840);
      rd_csr(a_ctl, 32'h23e0_0040);
    end
    rd_csr(a_sel, 32'h3);
    wr_csr(a_sel, 32'h0);
    wr_csr(a_cmp, 32'h1234_5678);
    wr_csr(a_sel, 32'h1);
    wr_csr(a_cmp, 32'h1234_ffff);
    wr_csr(a_ctl, 32'h0000_00c0);
    stream(32'h1234_5678, 4'h3, 4'h2, 16'h0);
    stream(32'h1235_5678, 4'h2, 4'h0, 16'h0);
    stream(32'h1236_5678, 4'h0, 4'h0, 16'h0);
    mm = 1'b0;
    stream(32'h1234_5678, 4'h0, 4'h0, 16'h0);
    mm = 1'b1;
    $display("test chain done");
    dbg = 1'b1;
    wr_csr(a_ctl, 32'h0800_10c0);
    rd_csr(a_ctl, 32'h23e0_00c0);
    wr_csr(a_sel, 32'h0);
    rd_csr(a_ctl, 32'h23e0_0840);
    wr_csr(a_ctl, 32'h0800_0840);
    wr_csr(a_sel, 32'h1);
    wr_csr(a_ctl, 32'h0800_00c0);
    wr_csr(a_ctl, 32'h0800_10c0);
    rd_csr(a_ctl, 32'h2be0_10c0);
    stream(32'h1234_5678, 4'h3, 4'h2, 16'h0010);
    dbg = 1'b0;
    wr_csr(a_sel, 32'h0);
    wr_csr(a_ctl, 32'h0);
    wr_csr(a_cmp, 32'h0);
    rd_csr(a_ctl, 32'h2be0_0840);
    rd_csr(a_cmp, 32'h1234_5678);
    dbg = 1'b1;
    wr_csr(a_ctl, 32'h0000_0840);
    rd_csr(a_ctl, 32'h23e0_0040);
    stream(32'h1234_5678, 4'h3, 4'h3, 16'h0010);
    $display("test debug done");
    wr_csr(a_sel, 32'h2);
    wr_csr(a_cmp, 32'haaaa_0000);
    wr_csr(a_ctl, 32'h0800_1840);
    rd_csr(a_ctl, 32'h2be0_1840);
    wr_csr(a_sel, 32'h3);
    wr_csr(a_cmp, 32'haaaa_0000);
    stream(32'haaaa_0000, 4'hc, 4'h8, 16'h0000);
    $display("test pair done");
    complete_run;
  end
endmodule : trigger_chain_match_control_bench
